// ===== verilog/clt_pkg.sv
// Purpose: constants for the cathode, luminance and temperature register bank
// Assumes: registers reached on a byte-wide internal port of the serial link
// Notes:   offsets are the printed register addresses
// Function
// - bit 7 skips converter soft-start
// - bits 6-4 select converter clock duty
// - bits 3-2 select converter clock frequency
// - bits 1-0 select soft-start duration
// - pixel voltage ceiling code, reset 0Dh
// - manual level fixes output in modes 01/10
// - reference current coarse plus fine fields
// - dimming 1 percent per step, reset 1
// - dimming acts only in mode 00
// - temperature slope divider 6 bits, reset 17h
// - temperature offset 8 bits, reset 3Ah
// - temperature refresh every N+1 frames
// - supply mode 00 auto, 01 clamped, 10 manual
// - conversions stored in 8-bit read-only readout
package clt_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CONV_CTRL   = 8'h0F;
  localparam logic [7:0] OFF_PIX_CEIL    = 8'h10;
  localparam logic [7:0] OFF_MAN_LEVEL   = 8'h11;
  localparam logic [7:0] OFF_REF_CUR     = 8'h12;
  localparam logic [7:0] OFF_DIMMING     = 8'h13;
  localparam logic [7:0] OFF_TSLOPE      = 8'h14;
  localparam logic [7:0] OFF_TOFFSET     = 8'h15;
  localparam logic [7:0] OFF_TINTERVAL   = 8'h16;
  localparam logic [7:0] OFF_TREADING    = 8'h17;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CONV_CTRL   = 8'h3D;
  localparam logic [7:0] RST_PIX_CEIL    = 8'h0D;
  localparam logic [7:0] RST_MAN_LEVEL   = 8'h51;
  localparam logic [7:0] RST_REF_CUR     = 8'h00;
  localparam logic [6:0] RST_DIMMING     = 7'h01;
  localparam logic [5:0] RST_TSLOPE      = 6'h17;
  localparam logic [7:0] RST_TOFFSET     = 8'h3A;
  localparam logic [7:0] RST_TINTERVAL   = 8'hFF;
  // ==========================================================
  // field positions in the converter control and reference current registers
  localparam int BIT_SS_BYPASS = 7;
  localparam int DUTY_LSB      = 4;
  localparam int FREQ_LSB      = 2;
  localparam int SS_LSB        = 0;
  localparam int COARSE_LSB    = 5;
  // ==========================================================
  // converter supply modes
  typedef enum logic [1:0] {
    CLT_MODE_AUTO    = 2'b00,
    CLT_MODE_CLAMPED = 2'b01,
    CLT_MODE_MANUAL  = 2'b10,
    CLT_MODE_RSVD    = 2'b11
  } clt_mode_t;
endpackage

// ===== verilog/clt_temp_if.sv
`timescale 1ns/1ps
// Purpose: carries temperature sensor controls between bank and scheduler
// Assumes: one clock domain
// Notes:   none
interface clt_temp_if;
  logic [7:0] interval;   // frames per update minus one
  logic       frame_tick; // one pulse per video frame
  logic       sample;     // conversion request pulse
  modport bank  (output interval, output frame_tick, input sample);
  modport sched (input interval, input frame_tick, output sample);
endinterface

// ===== verilog/clt_temp_sched.sv
`timescale 1ns/1ps
// Purpose: requests a temperature conversion every interval+1 frames
// Assumes: frame_tick is a single-cycle pulse
// Notes:   interval change takes effect at the next frame_tick compare
module clt_temp_sched (
  input wire logic  mclk,         // device clock
  input wire logic  nrst,         // async reset, active low
  clt_temp_if.sched tif           // link to register bank
);
  logic [7:0] frame_cnt;
  // ==========================================================
  // frame counter, pulses sample on the (N+1)th frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_cnt  <= 8'h00;
      tif.sample <= 1'b0;
    end else begin
      tif.sample <= 1'b0;
      if (tif.frame_tick) begin
        if (frame_cnt >= tif.interval) begin
          frame_cnt  <= 8'h00;
          tif.sample <= 1'b1;
        end else begin
          frame_cnt <= frame_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// ===== verilog/clt_regs.sv
`timescale 1ns/1ps
// Purpose: cathode converter, luminance and temperature sensor registers
// Assumes: byte write strobe and register offset from the serial control port decoder; reads need no strobe
// Notes:   analog circuits sit outside; fields are driven out as codes
module clt_regs (
  input  wire logic       mclk,           // device clock, 125 MHz
  input  wire logic       nrst,           // async reset, active low
  input  wire logic [7:0] reg_addr,       // register offset
  input  wire logic       reg_wr,         // write strobe
  input  wire logic [7:0] reg_wdata,      // write data
  output logic      [7:0] reg_rdata,      // read data
  output logic            reg_hit,        // address belongs to this bank
  input  wire logic [1:0] converter_supply_mode, // mode from mode register
  input  wire logic       frame_start,    // one pulse per video frame
  input  wire logic       temp_done,      // conversion finished pulse
  input  wire logic [7:0] temp_code,      // converted temperature
  output logic            temp_sample,    // conversion request pulse
  output logic            softstart_en,   // converter soft-start active
  output logic      [2:0] converter_clk_duty, // duty code 0..7
  output logic      [1:0] converter_clk_freq, // frequency code
  output logic      [1:0] softstart_duration, // soft-start time code
  output logic      [7:0] pixel_voltage_ceiling, // ceiling code
  output logic      [7:0] manual_level,   // manual inverter level
  output logic            manual_level_en, // manual level applies
  output logic      [2:0] refcur_coarse,  // coarse current code
  output logic      [4:0] refcur_fine,    // fine current in 1/32
  output logic      [6:0] dimming_code,   // effective dimming percent
  output logic      [5:0] temp_slope_divider, // sensor slope divider
  output logic      [7:0] temp_offset_adjust  // sensor offset
);
  logic [7:0] cathode_converter_control;
  logic [7:0] manual_cathode_level;
  logic [7:0] array_reference_current;
  logic [6:0] dimming_level;
  logic [7:0] temp_update_interval;
  logic [7:0] temp_reading;
  logic [7:0] next_rdata;
  clt_temp_if tif ();

  // ==========================================================
  // write decode helper
  function automatic logic wr_at(input logic [7:0] off);
    wr_at = reg_wr && (reg_addr == off);
  endfunction

  // ==========================================================
  // converter control and level registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cathode_converter_control <= clt_pkg::RST_CONV_CTRL;
      pixel_voltage_ceiling     <= clt_pkg::RST_PIX_CEIL;
      manual_cathode_level      <= clt_pkg::RST_MAN_LEVEL;
    end else begin
      if (wr_at(clt_pkg::OFF_CONV_CTRL)) begin
        cathode_converter_control <= reg_wdata;
      end
      if (wr_at(clt_pkg::OFF_PIX_CEIL)) begin
        pixel_voltage_ceiling <= reg_wdata;
      end
      if (wr_at(clt_pkg::OFF_MAN_LEVEL)) begin
        manual_cathode_level <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // luminance registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      array_reference_current <= clt_pkg::RST_REF_CUR;
      dimming_level           <= clt_pkg::RST_DIMMING;
    end else begin
      if (wr_at(clt_pkg::OFF_REF_CUR)) begin
        array_reference_current <= reg_wdata;
      end
      if (wr_at(clt_pkg::OFF_DIMMING)) begin
        dimming_level <= reg_wdata[6:0];
      end
    end
  end

  // ==========================================================
  // temperature sensor registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      temp_slope_divider   <= clt_pkg::RST_TSLOPE;
      temp_offset_adjust   <= clt_pkg::RST_TOFFSET;
      temp_update_interval <= clt_pkg::RST_TINTERVAL;
    end else begin
      if (wr_at(clt_pkg::OFF_TSLOPE)) begin
        temp_slope_divider <= reg_wdata[5:0];
      end
      if (wr_at(clt_pkg::OFF_TOFFSET)) begin
        temp_offset_adjust <= reg_wdata;
      end
      if (wr_at(clt_pkg::OFF_TINTERVAL)) begin
        temp_update_interval <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // read-only temperature readout, loaded on conversion end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      temp_reading <= 8'h00;
    end else if (temp_done) begin
      temp_reading <= temp_code;
    end
  end

  // ==========================================================
  // field decode to the analog side
  always_comb begin
    softstart_en       = ~cathode_converter_control[clt_pkg::BIT_SS_BYPASS];
    converter_clk_duty = cathode_converter_control[clt_pkg::DUTY_LSB +: 3];
    converter_clk_freq = cathode_converter_control[clt_pkg::FREQ_LSB +: 2];
    softstart_duration = cathode_converter_control[clt_pkg::SS_LSB +: 2];
  end
  // fields above; duty code 7 is passed unmodified

  // mode-dependent selection of manual level and dimming
  always_comb begin
    manual_level    = manual_cathode_level;
    manual_level_en = 1'b0;
    dimming_code    = 7'h00;
    case (clt_pkg::clt_mode_t'(converter_supply_mode))
      clt_pkg::CLT_MODE_AUTO: begin
        dimming_code = dimming_level;
      end
      clt_pkg::CLT_MODE_CLAMPED: begin
        manual_level_en = 1'b1;
      end
      clt_pkg::CLT_MODE_MANUAL: begin
        manual_level_en = 1'b1;
      end
      default: begin
        manual_level_en = 1'b0;
      end
    endcase
  end

  // reference current split into coarse and fine
  always_comb begin
    refcur_coarse = array_reference_current[clt_pkg::COARSE_LSB +: 3];
    refcur_fine   = array_reference_current[4:0];
  end

  // ==========================================================
  // read mux, registered data
  always_comb begin
    next_rdata = 8'h00;
    reg_hit    = 1'b1;
    case (reg_addr)
      clt_pkg::OFF_CONV_CTRL: next_rdata = cathode_converter_control;
      clt_pkg::OFF_PIX_CEIL:  next_rdata = pixel_voltage_ceiling;
      clt_pkg::OFF_MAN_LEVEL: next_rdata = manual_cathode_level;
      clt_pkg::OFF_REF_CUR:   next_rdata = array_reference_current;
      clt_pkg::OFF_DIMMING:   next_rdata = {1'b0, dimming_level};
      clt_pkg::OFF_TSLOPE:    next_rdata = {2'b00, temp_slope_divider};
      clt_pkg::OFF_TOFFSET:   next_rdata = temp_offset_adjust;
      clt_pkg::OFF_TINTERVAL: next_rdata = temp_update_interval;
      clt_pkg::OFF_TREADING:  next_rdata = temp_reading;
      default:                reg_hit    = 1'b0;
    endcase
  end

  // read data register, returns the addressed register one cycle later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // temperature update scheduling
  assign tif.interval   = temp_update_interval;
  assign tif.frame_tick = frame_start;
  assign temp_sample    = tif.sample;

  clt_temp_sched u_sched (
    .mclk (mclk),
    .nrst (nrst),
    .tif  (tif)
  );
endmodule

// ===== dv/clt_regs_assertions.sv
// Purpose: port-level checks of the cathode and temperature register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every clt_regs instance
`timescale 1ns/1ps
module clt_regs_assertions (
  input wire logic       mclk,                  // device clock
  input wire logic       nrst,                  // reset, active low
  input wire logic [7:0] reg_addr,              // register offset
  input wire logic       reg_wr,                // write strobe
  input wire logic [7:0] reg_wdata,             // write data
  input wire logic [7:0] reg_rdata,             // read data
  input wire logic       reg_hit,               // bank hit
  input wire logic [1:0] converter_supply_mode, // supply mode
  input wire logic       temp_sample,           // conversion request
  input wire logic       softstart_en,          // soft-start active
  input wire logic [2:0] converter_clk_duty,    // duty code
  input wire logic [1:0] converter_clk_freq,    // frequency code
  input wire logic       manual_level_en,       // manual level applies
  input wire logic [6:0] dimming_code,          // effective dimming
  input wire logic [5:0] temp_slope_divider     // slope divider
);
  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic wc;
  // write to the converter control register
  assign wc = reg_wr && reg_addr == 8'h0F;
  property p_ss; wc |=> softstart_en == !$past(reg_wdata[7]); endproperty
  a_ss: assert property (p_ss) else $error("soft-start enable wrong");
  property p_duty; wc |=> converter_clk_duty == $past(reg_wdata[6:4]);
  endproperty
  a_duty: assert property (p_duty) else $error("duty code wrong");
  property p_freq; wc |=> converter_clk_freq == $past(reg_wdata[3:2]);
  endproperty
  a_freq: assert property (p_freq) else $error("freq code wrong");
  property p_slope; reg_wr && reg_addr == 8'h14
    |=> temp_slope_divider == $past(reg_wdata[5:0]); endproperty
  a_slope: assert property (p_slope) else $error("slope wrong");
  property p_dim; converter_supply_mode != 2'h0 |-> dimming_code == 7'h00;
  endproperty
  a_dim: assert property (p_dim) else $error("dimming leaks");
  property p_man; manual_level_en == (converter_supply_mode == 2'h1
    || converter_supply_mode == 2'h2); endproperty
  a_man: assert property (p_man) else $error("manual enable wrong");
  property p_pulse; temp_sample |=> !temp_sample; endproperty
  a_pulse: assert property (p_pulse) else $error("sample too long");
  property p_unm; !reg_hit |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hit; reg_hit == (reg_addr >= 8'h0F && reg_addr <= 8'h17);
  endproperty
  a_hit: assert property (p_hit) else $error("hit decode wrong");
endmodule
bind clt_regs clt_regs_assertions u_chk (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .temp_sample(temp_sample),
  .converter_supply_mode(converter_supply_mode),
  .softstart_en(softstart_en), .converter_clk_duty(converter_clk_duty),
  .converter_clk_freq(converter_clk_freq), .dimming_code(dimming_code),
  .manual_level_en(manual_level_en),
  .temp_slope_divider(temp_slope_divider));

// ===== dv/clt_sensor_model.sv
// Purpose: temperature converter standing behind the bank
// Assumes: one request at a time
// Notes:   result is only meaningful while done is high
`timescale 1ns/1ps
module clt_sensor_model (
  input  wire logic       mclk,        // device clock
  input  wire logic       nrst,        // reset, active low
  input  wire logic       temp_sample, // conversion request
  input  wire logic [7:0] code,        // value the sensor reports
  output logic            temp_done,   // conversion finished pulse
  output logic      [7:0] temp_code    // conversion result
);
  logic [1:0] busy;
  // answer three cycles after a request; inverse shown when idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy <= 2'h0;
      temp_done <= 1'b0;
      temp_code <= 8'h00;
    end else begin
      busy <= {busy[0], temp_sample};
      temp_done <= busy[1];
      temp_code <= busy[1] ? code : ~code;
    end
  end
endmodule

// ===== dv/test_clt_regs.sv
// Purpose: self-checking bench of the register bank
// Assumes: stimulus at falling edge, fixed seed
// Notes:   sensor model closes the conversion loop
`timescale 1ns/1ps
module test_clt_regs;
  logic       mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, frame_start = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tcode = 8'h00;
  logic [1:0] converter_supply_mode = 2'h0;
  logic [7:0] reg_rdata, temp_code, pixel_voltage_ceiling, manual_level;
  logic [7:0] temp_offset_adjust, v[8];
  logic [6:0] dimming_code;
  logic [5:0] temp_slope_divider;
  logic [4:0] refcur_fine;
  logic [2:0] converter_clk_duty, refcur_coarse;
  logic [1:0] converter_clk_freq, softstart_duration;
  logic       reg_hit, temp_done, temp_sample, softstart_en, manual_level_en;
  int         errors = 0, checks = 0, cyc = 0, fcnt = 0, gap = 0, nsamp = 0;
  logic [7:0] rst[8] = '{8'h3D, 8'h0D, 8'h51, 8'h00, 8'h01, 8'h17, 8'h3A,
                         8'hFF};
  logic [7:0] msk[8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'hFF,
                         8'hFF};
  // ==========================================================
  // design, sensor, clock, watchdog
  clt_regs dut_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .converter_supply_mode(converter_supply_mode),
    .frame_start(frame_start), .temp_done(temp_done),
    .temp_code(temp_code), .temp_sample(temp_sample),
    .softstart_en(softstart_en), .converter_clk_duty(converter_clk_duty),
    .converter_clk_freq(converter_clk_freq),
    .softstart_duration(softstart_duration),
    .pixel_voltage_ceiling(pixel_voltage_ceiling),
    .manual_level(manual_level), .manual_level_en(manual_level_en),
    .refcur_coarse(refcur_coarse), .refcur_fine(refcur_fine),
    .dimming_code(dimming_code), .temp_slope_divider(temp_slope_divider),
    .temp_offset_adjust(temp_offset_adjust));
  clt_sensor_model sens_u (.mclk(mclk), .nrst(nrst), .code(tcode),
    .temp_sample(temp_sample), .temp_done(temp_done), .temp_code(temp_code));
  initial forever #4 mclk = ~mclk;
  // cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  // frames between conversion requests
  always @(posedge mclk) begin
    if (temp_sample === 1'b1) begin
      nsamp++;
      gap = fcnt;
      fcnt = 0;
    end else if (frame_start) fcnt++;
  end
  // ==========================================================
  // tasks
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge mclk) reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge mclk) reg_addr = a;
    @(negedge mclk) chk("rdata", e, reg_rdata);
  endtask
  task automatic frames(int k);
    repeat (k) begin
      @(negedge mclk) frame_start = 1'b1;
      @(negedge mclk) frame_start = 1'b0;
      repeat (3) @(negedge mclk);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int i;
    void'($urandom(32'h198044B4));
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    for (i = 0; i < 8; i++) rd(8'(i) + 8'h0F, rst[i]);
    rd(8'h17, 8'h00);
    for (i = 0; i < 8; i++) begin
      v[i] = 8'($urandom);
      if (i == 7 && v[i] < 8'h02) v[i] = 8'h02;
      wr(8'(i) + 8'h0F, v[i]);
      v[i] = v[i] & msk[i];
      rd(8'(i) + 8'h0F, v[i]);
    end
    chk("softstart", !v[0][7], softstart_en);
    chk("duty", v[0][6:4], converter_clk_duty);
    chk("freq", v[0][3:2], converter_clk_freq);
    chk("ss time", v[0][1:0], softstart_duration);
    chk("ceiling", v[1], pixel_voltage_ceiling);
    chk("manual", v[2], manual_level);
    chk("refcur", v[3], {refcur_coarse, refcur_fine});
    chk("slope", v[5], temp_slope_divider);
    chk("offset", v[6], temp_offset_adjust);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h7F);
    for (i = 0; i < 4; i++) begin
      @(negedge mclk) converter_supply_mode = 2'(i);
      #1 chk("dimming", i == 0 ? 8'h7F : 8'h00, dimming_code);
      chk("man en", i == 1 || i == 2, manual_level_en);
    end
    rd(8'h20, 8'h00);
    chk("hit", 8'h00, reg_hit);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h00);
    tcode = 8'($urandom);
    wr(8'h16, 8'h02);
    frames(12);
    chk("frames", 8'h03, 8'(gap));
    chk("samples", 8'h04, 8'(nsamp));
    rd(8'h17, tcode);
    // second reset in mid-run must reload every register and the readout
    @(negedge mclk) nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    for (i = 0; i < 8; i++) rd(8'(i) + 8'h0F, rst[i]);
    rd(8'h17, 8'h00);
    close_out();
  end
endmodule
